// *** core/smi_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module smi_top
	import smi_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [6:0] pcm_slot,
	output logic pcm_slot_drive,
	input wire logic [7:0] cfi_slot,
	output logic [3:0] cfi_slot_code,
	output logic [7:0] cfi_slot_data,
	output logic reference_clock
);

	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] access_data_byte;
		logic [7:0] access_location_byte;
		logic [7:0] access_command_byte;
		logic [1:0] operation_select_field;
		logic pcm_output_enable;
		logic [7:0] ref_div;
		logic [7:0] div_cnt;
		logic half_ph;
		logic access_busy_flag;
		smi_op_e op;
		logic [11:0] op_cnt;
		logic [7:0] idx;
		logic pcm_drive;
	} smi_state_s;

	smi_state_s s;
	smi_state_s next_s;
	smi_mem_if mem ();

	logic half_tick;
	logic ref_tick;
	logic wr_fire;
	logic [11:0] single_len;

	// Known register addresses; shared by the write and read decoders.
	function automatic logic smi_addr_ok(input logic [7:0] a);
		return a == ADDR_DATA || a == ADDR_LOC || a == ADDR_CMD ||
			a == ADDR_STATUS || a == ADDR_CTRL || a == ADDR_FRAME;
	endfunction : smi_addr_ok

	smi_mem u_mem (
		.aclk(aclk),
		.mem(mem)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reference clock: one half period every ref_div+1 bus clocks.
	assign half_tick = s.div_cnt == s.ref_div;
	assign ref_tick = half_tick && s.half_ph;
	assign wr_fire = s.aw_full && s.w_full && !s.bvalid;
	// The fast single access only applies in initialization mode.
	assign single_len = (s.operation_select_field == MODE_CM_INIT) ? SINGLE_FAST_HALF
		: SINGLE_NORM_HALF;

	// Bus handshakes are combinational; data outputs come from flops.
	assign s_axi_awready = !s.aw_full;
	assign s_axi_wready = !s.w_full;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign reference_clock = s.half_ph;
	assign pcm_slot_drive = s.pcm_drive;
	assign cfi_slot_code = mem.cm_rcode;
	assign cfi_slot_data = mem.cm_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic for bus slave, registers and operation sequencer.
	always_comb begin
		next_s = s;
		mem.cm_we = 1'b0;
		mem.cm_addr = s.access_location_byte;
		mem.cm_wcode = s.access_command_byte[3:0];
		mem.cm_wdata = s.access_data_byte;
		mem.cm_raddr = cfi_slot;
		mem.ts_we = 1'b0;
		mem.ts_addr = s.idx[6:0];
		mem.ts_wval = s.access_data_byte[3:0];
		mem.ts_raddr = pcm_slot;

		// Reference clock divider runs freely.
		next_s.div_cnt = half_tick ? 8'h00 : s.div_cnt + 8'h01;
		if (half_tick) begin
			next_s.half_ph = !s.half_ph;
		end

		// Write address and data are taken in either order.
		if (s_axi_awvalid && !s.aw_full) begin
			next_s.aw_full = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_full) begin
			next_s.w_full = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		// A write completes once both halves are held and no response is pending.
		if (wr_fire) begin
			next_s.aw_full = 1'b0;
			next_s.w_full = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = smi_addr_ok(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (s.w_strb[0]) begin
				case (s.aw_addr)
					ADDR_DATA: begin
						next_s.access_data_byte = s.w_data[7:0];
					end
					ADDR_LOC: begin
						next_s.access_location_byte = s.w_data[7:0];
					end
					ADDR_CTRL: begin
						next_s.operation_select_field = s.w_data[CTRL_MODE_LSB +: 2];
						next_s.pcm_output_enable = s.w_data[CTRL_PCM_EN_BIT];
					end
					ADDR_FRAME: begin
						// Taken whatever the operation mode is.
						next_s.ref_div = s.w_data[7:0];
						next_s.div_cnt = 8'h00;
					end
					ADDR_CMD: begin
						// A command while busy is dropped; software must poll first.
						if (s.op == SMI_IDLE) begin
							next_s.access_command_byte = s.w_data[7:0];
							next_s.op_cnt = 12'h000;
							next_s.idx = 8'h00;
							if (s.w_data[7:4] == CMD_CM_WRITE_NIB) begin
								// Code 0 in reset mode clears the whole memory.
								if (s.operation_select_field == MODE_RESET &&
									s.w_data[3:0] == CM_CODE_UNASSIGNED) begin
									next_s.op = SMI_CMRST;
								end else begin
									next_s.op = SMI_SINGLE;
								end
								next_s.access_busy_flag = 1'b1;
							end else if (s.w_data[7:0] == CMD_TS_RESET &&
								s.operation_select_field == MODE_NORMAL) begin
								next_s.op = SMI_TSRST;
								next_s.access_busy_flag = 1'b1;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end

		// Reads answer one cycle after the address is taken.
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = smi_addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			next_s.rdata = 32'h00000000;
			case (s_axi_araddr)
				ADDR_DATA: next_s.rdata[7:0] = s.access_data_byte;
				ADDR_LOC: next_s.rdata[7:0] = s.access_location_byte;
				ADDR_CMD: next_s.rdata[7:0] = s.access_command_byte;
				ADDR_STATUS: next_s.rdata[STATUS_BUSY_BIT] = s.access_busy_flag;
				ADDR_CTRL: begin
					next_s.rdata[CTRL_MODE_LSB +: 2] = s.operation_select_field;
					next_s.rdata[CTRL_PCM_EN_BIT] = s.pcm_output_enable;
				end
				ADDR_FRAME: next_s.rdata[7:0] = s.ref_div;
				default: begin
				end
			endcase
		end

		// Operation sequencer, paced by the reference clock.
		case (s.op)
			SMI_IDLE: begin
			end
			SMI_SINGLE: begin
				// The location is written at the end of the access time.
				if (half_tick) begin
					next_s.op_cnt = s.op_cnt + 12'h001;
					if (s.op_cnt == single_len - 12'h001) begin
						// Low nibble is the stored code; the data byte goes alongside.
						mem.cm_we = 1'b1;
						next_s.op = SMI_IDLE;
						next_s.access_busy_flag = 1'b0;
					end
				end
			end
			SMI_CMRST: begin
				// One location per reference cycle, so the full sweep takes the whole count.
				if (ref_tick) begin
					mem.cm_we = 1'b1;
					mem.cm_addr = s.idx;
					mem.cm_wcode = CM_CODE_UNASSIGNED;
					next_s.idx = s.idx + 8'h01;
					next_s.op_cnt = s.op_cnt + 12'h001;
					if (s.op_cnt == CM_RESET_REF - 12'h001) begin
						next_s.op = SMI_IDLE;
						next_s.access_busy_flag = 1'b0;
					end
				end
			end
			SMI_TSRST: begin
				// Locations fill early; busy holds for the full documented time.
				if (ref_tick) begin
					if (!s.idx[7]) begin
						mem.ts_we = 1'b1;
						next_s.idx = s.idx + 8'h01;
					end
					next_s.op_cnt = s.op_cnt + 12'h001;
					if (s.op_cnt == TS_RESET_REF - 12'h001) begin
						next_s.op = SMI_IDLE;
						next_s.access_busy_flag = 1'b0;
					end
				end
			end
			default: begin
				next_s.op = SMI_IDLE;
				next_s.access_busy_flag = 1'b0;
			end
		endcase

		// Slot driven only when output is enabled and its tristate value is all ones.
		next_s.pcm_drive = s.pcm_output_enable && mem.ts_rval == TS_LOW_Z;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.access_data_byte <= BYTE_RST;
			s.access_location_byte <= BYTE_RST;
			s.access_command_byte <= BYTE_RST;
			s.operation_select_field <= CTRL_MODE_RST;
			s.pcm_output_enable <= CTRL_PCM_EN_RST;
			s.ref_div <= FRAME_DIV_RST;
			s.op <= SMI_IDLE;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helper for checks: reference cycles seen during the current operation.
	logic [11:0] hlp_refs;
	smi_op_e hlp_last;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hlp_refs <= 12'h000;
			hlp_last <= SMI_IDLE;
		end else if (s.op == SMI_IDLE) begin
			hlp_refs <= 12'h000;
		end else begin
			hlp_last <= s.op;
			if (ref_tick) begin
				hlp_refs <= hlp_refs + 12'h001;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_busy_after_cmd: assert property (wr_fire && s.aw_addr == ADDR_CMD && s.w_strb[0] && s.op == SMI_IDLE && s.w_data[7:4] == CMD_CM_WRITE_NIB |=> s.access_busy_flag) else $error("busy not set after command");
	a_cm_reset_len: assert property ($fell(s.access_busy_flag) && hlp_last == SMI_CMRST |-> $past(hlp_refs) == CM_RESET_REF - 12'h001) else $error("memory reset length wrong");
	a_ts_reset_len: assert property ($fell(s.access_busy_flag) && hlp_last == SMI_TSRST |-> $past(hlp_refs) == TS_RESET_REF - 12'h001) else $error("tristate reset length wrong");
	// The sweep address is held against the independent helper count, so a skipped location shows.
	a_cm_reset_code: assert property (s.op == SMI_CMRST && mem.cm_we |-> mem.cm_wcode == CM_CODE_UNASSIGNED && mem.cm_addr == hlp_refs[7:0]) else $error("memory reset wrote a used code");
	a_single_code: assert property (s.op == SMI_SINGLE && mem.cm_we |-> mem.cm_wcode == s.access_command_byte[3:0] && mem.cm_addr == s.access_location_byte) else $error("single write code or address wrong");
	a_ts_copy: assert property (mem.ts_we |-> s.op == SMI_TSRST && hlp_refs < 12'h080 && mem.ts_addr == hlp_refs[6:0] && mem.ts_wval == s.access_data_byte[3:0]) else $error("tristate fill value wrong");
	a_pcm_hiz: assert property (!s.pcm_output_enable |=> !pcm_slot_drive) else $error("pcm slot driven while disabled");
	a_busy_matches_op: assert property (s.access_busy_flag == (s.op != SMI_IDLE)) else $error("busy flag out of step");
	a_cfg_any_mode: assert property (wr_fire && s.aw_addr == ADDR_FRAME && s.w_strb[0] |=> s.ref_div == $past(s.w_data[7:0])) else $error("frame config write lost");
	a_bresp_hold: assert property (s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp)) else $error("write response dropped");

	c_cm_reset: cover property ($fell(s.access_busy_flag) && hlp_last == SMI_CMRST);
	c_ts_reset: cover property ($fell(s.access_busy_flag) && hlp_last == SMI_TSRST);
	c_fast_single: cover property (s.op == SMI_SINGLE && mem.cm_we && s.operation_select_field == MODE_CM_INIT);
	c_slot_driven: cover property (pcm_slot_drive);

endmodule : smi_top

`default_nettype wire

// *** core/smi_pkg.sv ***
package smi_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses on the AXI4-Lite bus.
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_LOC = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [7:0] ADDR_FRAME = 8'h14;

	// Field positions.
	localparam int STATUS_BUSY_BIT = 0;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PCM_EN_BIT = 2;
	localparam int LOC_DIR_BIT = 7;

	// Values after reset.
	localparam logic [1:0] CTRL_MODE_RST = 2'h0;
	localparam logic CTRL_PCM_EN_RST = 1'b0;
	localparam logic [7:0] FRAME_DIV_RST = 8'h01;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Operation select codes.
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] MODE_CM_INIT = 2'h2;
	localparam logic [1:0] MODE_NORMAL = 2'h3;

	// Command and memory codes.
	localparam logic [3:0] CMD_CM_WRITE_NIB = 4'h7;
	localparam logic [7:0] CMD_TS_RESET = 8'h68;
	localparam logic [3:0] CM_CODE_UNASSIGNED = 4'h0;
	localparam logic [3:0] TS_LOW_Z = 4'hF;

	// Memory sizes and operation lengths in reference-clock cycles.
	localparam int CM_DEPTH = 256;
	localparam int TS_DEPTH = 128;
	localparam logic [11:0] CM_RESET_REF = 12'h100;
	localparam logic [11:0] TS_RESET_REF = 12'h40B;
	// Single access lengths in reference-clock half cycles (2.5 and 4 cycles).
	localparam logic [11:0] SINGLE_FAST_HALF = 12'h005;
	localparam logic [11:0] SINGLE_NORM_HALF = 12'h008;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		SMI_IDLE = 4'b0001,
		SMI_SINGLE = 4'b0010,
		SMI_CMRST = 4'b0100,
		SMI_TSRST = 4'b1000
	} smi_op_e;

endpackage : smi_pkg

// *** core/smi_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Write and read ports between the sequencer and the memory arrays.
interface smi_mem_if;
	logic cm_we;
	logic [7:0] cm_addr;
	logic [3:0] cm_wcode;
	logic [7:0] cm_wdata;
	logic [7:0] cm_raddr;
	logic [3:0] cm_rcode;
	logic [7:0] cm_rdata;
	logic ts_we;
	logic [6:0] ts_addr;
	logic [3:0] ts_wval;
	logic [6:0] ts_raddr;
	logic [3:0] ts_rval;

	modport ctrl (
		output cm_we, cm_addr, cm_wcode, cm_wdata, cm_raddr,
		output ts_we, ts_addr, ts_wval, ts_raddr,
		input cm_rcode, cm_rdata, ts_rval
	);
	modport store (
		input cm_we, cm_addr, cm_wcode, cm_wdata, cm_raddr,
		input ts_we, ts_addr, ts_wval, ts_raddr,
		output cm_rcode, cm_rdata, ts_rval
	);
endinterface : smi_mem_if

`default_nettype wire

// *** core/smi_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module smi_mem
	import smi_pkg::*;
(
	input wire logic aclk,
	smi_mem_if.store mem
);

	// The arrays deliberately have no reset: contents survive a reset and are cleared by command.
	logic [11:0] cm_array [CM_DEPTH];
	logic [3:0] ts_array [TS_DEPTH];

	////////////////////////////////////////////////////////////////////////////////
	// Synchronous write, registered read for both arrays.
	always_ff @(posedge aclk) begin
		if (mem.cm_we) begin
			cm_array[mem.cm_addr] <= {mem.cm_wcode, mem.cm_wdata};
		end
		if (mem.ts_we) begin
			ts_array[mem.ts_addr] <= mem.ts_wval;
		end
		{mem.cm_rcode, mem.cm_rdata} <= cm_array[mem.cm_raddr];
		mem.ts_rval <= ts_array[mem.ts_raddr];
	end

endmodule : smi_mem

`default_nettype wire

// *** verification/smi_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host processor model: an AXI4-Lite master that issues memory access commands.
module smi_host
	import smi_pkg::*;
(
	input wire logic aclk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);

	// Every request line is idle from time zero.
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h00000000;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address and data are offered together; each is released at its own handshake.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awready && !ad) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !wd) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	// The address is dropped once taken; the answer is taken when rvalid is seen.
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	// A new access is only issued once the busy flag reads zero.
	task automatic poll(output time tp);
		logic [31:0] v;
		logic [1:0] r;
		do rd(ADDR_STATUS, v, r); while (v[STATUS_BUSY_BIT] !== 1'b0);
		tp = $time;
	endtask : poll

endmodule : smi_host

`default_nettype wire

// *** verification/tb_switch_memory_init_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin err_total++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end

module tb_switch_memory_init_sequencer
	import smi_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr, araddr, cfi_slot_data;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, pcm_slot_drive, reference_clock;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [3:0] cfi_slot_code;
	logic [6:0] pcm_slot = 7'h00;
	logic [7:0] cfi_slot = 8'h00;
	logic [7:0] rnd = 8'h4D;
	logic [7:0] loc_tab [4] = '{8'h08, 8'h09, 8'h88, 8'h89};
	logic [7:0] cmd_tab [4] = '{8'h7A, 8'h7B, 8'h78, 8'h70};
	int err_total = 0;
	int n_checks = 0;
	int tmo = 0;
	int div = 1;
	time tc = 0;

	// Clock at 40 MHz.
	always #12.5 aclk = ~aclk;

	smi_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pcm_slot(pcm_slot), .pcm_slot_drive(pcm_slot_drive), .cfi_slot(cfi_slot),
		.cfi_slot_code(cfi_slot_code), .cfi_slot_data(cfi_slot_data),
		.reference_clock(reference_clock));

	smi_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));

	////////////////////////////////////////////////////////////////////////////////
	// Expectation helpers: random source, operation length in aclk, slot drive.
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nx

	function automatic int span(input int half);
		return half * (div + 1);
	endfunction : span

	function automatic logic drv(input logic en, input logic [3:0] v);
		return en && (v == TS_LOW_Z);
	endfunction : drv

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	// Polling adds a few cycles of latency, so the window is wider above than below.
	task automatic len(input string nm, input time tp, input int e);
		int m;
		m = int'((tp - tc) / 25);
		`CHK(nm, 1'b1, (m >= e - 2) && (m <= e + 7))
	endtask : len

	task automatic cmd(input logic [7:0] x);
		logic [1:0] r;
		i_host.wr(ADDR_CMD, x, r);
		tc = $time;
	endtask : cmd

	task automatic look(input logic [7:0] a, output logic [3:0] c, output logic [7:0] d);
		@(posedge aclk);
		cfi_slot <= a;
		repeat (2) @(posedge aclk);
		#1;
		c = cfi_slot_code;
		d = cfi_slot_data;
	endtask : look

	task automatic slot(input logic [6:0] s, output logic t);
		@(posedge aclk);
		pcm_slot <= s;
		repeat (3) @(posedge aclk);
		#1 t = pcm_slot_drive;
	endtask : slot

	// Counts aclk edges between two toggles of the reference clock.
	task automatic ref_per(output int n);
		logic p;
		@(posedge aclk);
		p = reference_clock;
		do @(posedge aclk); while (reference_clock === p);
		n = 0;
		p = reference_clock;
		do begin
			@(posedge aclk);
			n++;
		end while (reference_clock === p);
	endtask : ref_per

	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		div = 1;
	endtask : do_reset

	// A hang is cut short well past the longest expected run.
	always @(posedge aclk) begin
		tmo <= tmo + 1;
		if (tmo == 40000) begin
			err_total++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin : main
		logic [31:0] v;
		logic [1:0] r;
		logic [3:0] c;
		logic [3:0] tv;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] x;
		logic t;
		time tp;
		int n;
		tv = TS_LOW_Z;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		i_host.rd(ADDR_STATUS, v, r);
		`CHK("status", 32'h00000000, v)
		i_host.rd(8'h18, v, r);
		`CHK("rresp", RESP_SLVERR, r)
		i_host.wr(8'h18, 8'h00, r);
		`CHK("bresp", RESP_SLVERR, r)
		ref_per(n);
		`CHK("ref_half", 2, n)
		i_host.wr(ADDR_CTRL, 8'h03, r);
		i_host.wr(ADDR_FRAME, 8'h00, r);
		`CHK("bresp", RESP_OKAY, r)
		div = 0;
		i_host.rd(ADDR_FRAME, v, r);
		`CHK("frame", 32'h00000000, v)
		ref_per(n);
		`CHK("ref_half", 1, n)
		// Memory clear with the mode field back at its reset value; a command is dropped.
		i_host.wr(ADDR_CTRL, 8'h00, r);
		rnd = nx(rnd);
		i_host.wr(ADDR_DATA, rnd, r);
		cmd(8'h70);
		i_host.rd(ADDR_STATUS, v, r);
		`CHK("busy", 32'h00000001, v)
		i_host.wr(ADDR_LOC, 8'h08, r);
		i_host.wr(ADDR_CMD, 8'h7A, r);
		i_host.poll(tp);
		len("cm_len", tp, span(512));
		for (int i = 0; i < 8; i++) begin
			rnd = nx(rnd);
			look((i == 0) ? 8'h08 : rnd, c, e);
			`CHK("cm_code", CM_CODE_UNASSIGNED, c)
		end
		// Subscriber channels are present, so the control slots are set up.
		i_host.wr(ADDR_CTRL, 8'h02, r);
		for (int i = 0; i < 16; i++) begin
			rnd = nx(rnd);
			a = (i < 4) ? loc_tab[i] : {rnd[7:4], 4'h0};
			x = (i < 4) ? cmd_tab[i] : {CMD_CM_WRITE_NIB, i[3:0]};
			rnd = nx(rnd);
			d = rnd;
			i_host.wr(ADDR_DATA, d, r);
			i_host.wr(ADDR_LOC, a, r);
			cmd(x);
			i_host.poll(tp);
			if (i == 0) len("fast_len", tp, span(5));
			look(a, c, e);
			`CHK("cm_code", x[3:0], c)
			`CHK("cm_data", d, e)
		end
		look(8'h08, c, e);
		`CHK("down_code", 4'hA, c)
		look(8'h88, c, e);
		`CHK("up_code", 4'h8, c)
		// Normal mode single access takes longer; tristate fill is refused outside it.
		i_host.wr(ADDR_CTRL, 8'h03, r);
		i_host.wr(ADDR_LOC, 8'h44, r);
		cmd(8'h7C);
		i_host.poll(tp);
		len("norm_len", tp, span(8));
		i_host.wr(ADDR_CTRL, 8'h00, r);
		cmd(CMD_TS_RESET);
		i_host.rd(ADDR_STATUS, v, r);
		`CHK("busy", 32'h00000000, v)
		// Tristate fills with output enable off, then on.
		for (int j = 0; j < 4; j++) begin
			i_host.wr(ADDR_CTRL, (j == 0) ? 8'h03 : 8'h07, r);
			if (j != 1) begin
				rnd = nx(rnd);
				tv = (j == 2) ? {rnd[3:1], 1'b0} : TS_LOW_Z;
				i_host.wr(ADDR_DATA, {rnd[7:4], tv}, r);
				cmd(CMD_TS_RESET);
				i_host.poll(tp);
				if (j == 0) len("ts_len", tp, span(2070));
			end
			for (int k = 0; k < 4; k++) begin
				rnd = nx(rnd);
				slot(k[1] ? rnd[6:0] : {7{k[0]}}, t);
				`CHK("drive", drv(j != 0, tv), t)
			end
		end
		// Memories keep their contents across a reset; a fill is cut short by one.
		do_reset();
		i_host.wr(ADDR_CTRL, 8'h07, r);
		slot(7'h05, t);
		`CHK("drive", 1'b1, t)
		look(8'h08, c, e);
		`CHK("cm_code", 4'hA, c)
		cmd(CMD_TS_RESET);
		repeat (20) @(posedge aclk);
		do_reset();
		i_host.rd(ADDR_STATUS, v, r);
		`CHK("busy", 32'h00000000, v)
		complete_run();
	end

endmodule : tb_switch_memory_init_sequencer

`default_nettype wire
